//--- werm_top.sv
/*
 * werm_top: wake-up event routing masks with an APB register slave.
 * Gates raw wake-up events toward their detectors, latches detected
 * events and routes them to one interrupt request line.
 * assumes: all inputs synchronous to ref_clk; detectors outside return
 * one-cycle pulses on detected_events; APB master per AMBA APB.
 * sw_reset and clk_en are sampled on the same edge as every other input.
 * no transfer may be made while clk_en is low, as all state is frozen.
 * gp gating with the main supply absent is fixed open, since that mask
 * is kept outside this block.
 * register map by byte address: 58h gp irq route, 5ch powered misc gate,
 * 60h powered gp gate, 64h unpowered misc gate, 6ch gp status,
 * 70h misc status, 74h misc irq route; any other address is refused.
 */
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module werm_top (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sw_reset,
    input wire logic main_supply_present,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [werm_pkg::APB_AW-1:0] paddr,
    input wire logic [werm_pkg::APB_DW-1:0] pwdata,
    output logic [werm_pkg::APB_DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire werm_pkg::werm_events_t raw_events,
    input wire werm_pkg::werm_events_t detected_events,
    output werm_pkg::werm_events_t gated_events,
    output logic wake_irq
);
    import werm_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [GP_N-1:0] gp_route;
    logic [MISC_N-1:0] misc_route;
    logic [MISC_N-1:0] misc_pwr;
    logic [GP_N-1:0] gp_pwr;
    logic [MISC_N-1:0] misc_unpwr;
    logic [GP_N-1:0] next_gp_route;
    logic [MISC_N-1:0] next_misc_route;
    logic [MISC_N-1:0] next_misc_pwr;
    logic [GP_N-1:0] next_gp_pwr;
    logic [MISC_N-1:0] next_misc_unpwr;
    logic [APB_DW-1:0] next_prdata;
    logic addr_hit;
    logic next_addr_hit;
    werm_events_t next_gated_events;
    logic next_wake_irq;
    logic [GP_N-1:0] gp_stat;
    logic [MISC_N-1:0] misc_stat;
    logic [GP_N-1:0] gp_clear;
    logic [MISC_N-1:0] misc_clear;
    logic setup_phase;
    logic wr_access;

    // write strobes
    logic wr_gp_route;
    logic wr_misc_route;
    logic wr_misc_pwr;
    logic wr_gp_pwr;
    logic wr_misc_unpwr;
    logic wr_gp_stat;
    logic wr_misc_stat;

    // read selection, gate selection and routed status
    logic [APB_DW-1:0] rd_value;
    logic [MISC_N-1:0] misc_gate_sel;
    logic [GP_N-1:0] gp_gate_sel;
    logic [GP_N-1:0] routed_gp;
    logic [MISC_N-1:0] routed_misc;

    function automatic logic reg_sel(input logic [APB_AW-1:0] a, input logic [7:0] idx);
        return a == werm_byte_addr(idx);
    endfunction : reg_sel

    // reserved bits 7-5 of the misc registers read as zero
    function automatic logic [7:0] misc_byte(input logic [MISC_N-1:0] v);
        return {{(8 - MISC_N){1'b0}}, v};
    endfunction : misc_byte

    function automatic logic decode_hit(input logic [APB_AW-1:0] a);
        return reg_sel(a, IDX_GP_ROUTE) || reg_sel(a, IDX_MISC_PWR)
            || reg_sel(a, IDX_GP_PWR) || reg_sel(a, IDX_MISC_UNPWR)
            || reg_sel(a, IDX_GP_STAT) || reg_sel(a, IDX_MISC_STAT)
            || reg_sel(a, IDX_MISC_ROUTE);
    endfunction : decode_hit

    ////////////////////////////////////////////////////////////////////////
    // apb handshake: zero wait states, error on unmapped access
    assign setup_phase = psel && !penable;
    // every access completes in its first access cycle
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign wr_access = psel && penable && pwrite && addr_hit;

    // read value of the addressed register
    always_comb begin
        rd_value = '0;
        unique case (paddr)
            werm_byte_addr(IDX_GP_ROUTE): rd_value = werm_word(gp_route);
            werm_byte_addr(IDX_MISC_PWR): rd_value = werm_word(misc_byte(misc_pwr));
            werm_byte_addr(IDX_GP_PWR): rd_value = werm_word(gp_pwr);
            werm_byte_addr(IDX_MISC_UNPWR): rd_value = werm_word(misc_byte(misc_unpwr));
            werm_byte_addr(IDX_GP_STAT): rd_value = werm_word(gp_stat);
            werm_byte_addr(IDX_MISC_STAT): rd_value = werm_word(misc_byte(misc_stat));
            werm_byte_addr(IDX_MISC_ROUTE): rd_value = werm_word(misc_byte(misc_route));
            default: rd_value = '0;
        endcase
    end

    // read data is captured in setup, so it stands through the access phase
    always_comb begin
        next_addr_hit = addr_hit;
        next_prdata = prdata;
        if (setup_phase) begin
            next_addr_hit = decode_hit(paddr);
            next_prdata = '0;
            if (!pwrite) begin
                next_prdata = rd_value;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_hit <= 1'b0;
            prdata <= '0;
        end else if (clk_en) begin
            addr_hit <= next_addr_hit;
            prdata <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // one write strobe per register, only in a decoded access phase
    // reserved and unmapped offsets get no strobe
    always_comb begin
        wr_gp_route = wr_access && reg_sel(paddr, IDX_GP_ROUTE);
        wr_misc_route = wr_access && reg_sel(paddr, IDX_MISC_ROUTE);
        wr_misc_pwr = wr_access && reg_sel(paddr, IDX_MISC_PWR);
        wr_gp_pwr = wr_access && reg_sel(paddr, IDX_GP_PWR);
        wr_misc_unpwr = wr_access && reg_sel(paddr, IDX_MISC_UNPWR);
        wr_gp_stat = wr_access && reg_sel(paddr, IDX_GP_STAT);
        wr_misc_stat = wr_access && reg_sel(paddr, IDX_MISC_STAT);
    end

    ////////////////////////////////////////////////////////////////////////
    // mask registers
    always_comb begin
        next_gp_route = gp_route;
        next_misc_route = misc_route;
        next_misc_pwr = misc_pwr;
        next_gp_pwr = gp_pwr;
        next_misc_unpwr = misc_unpwr;
        // sw_reset wins over a write in the same cycle
        if (sw_reset) begin
            next_gp_route = RST_GP_ROUTE;
            next_misc_route = RST_MISC_ROUTE;
            next_misc_pwr = RST_MISC_GATE;
            next_gp_pwr = RST_GP_GATE;
            next_misc_unpwr = RST_MISC_GATE;
        end else if (wr_access) begin
            if (wr_gp_route) begin
                next_gp_route = pwdata[GP_N-1:0];
            end
            if (wr_misc_route) begin
                next_misc_route = pwdata[MISC_N-1:0];
            end
            // reserved bits 7-5 are not stored
            if (wr_misc_pwr) begin
                next_misc_pwr = pwdata[MISC_N-1:0];
            end
            if (wr_gp_pwr) begin
                next_gp_pwr = pwdata[GP_N-1:0];
            end
            if (wr_misc_unpwr) begin
                next_misc_unpwr = pwdata[MISC_N-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gp_route <= RST_GP_ROUTE;
            misc_route <= RST_MISC_ROUTE;
            misc_pwr <= RST_MISC_GATE;
            gp_pwr <= RST_GP_GATE;
            misc_unpwr <= RST_MISC_GATE;
        end else if (clk_en) begin
            gp_route <= next_gp_route;
            misc_route <= next_misc_route;
            misc_pwr <= next_misc_pwr;
            gp_pwr <= next_gp_pwr;
            misc_unpwr <= next_misc_unpwr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write-one-to-clear of detected event status
    // a detector pulse in the same cycle as the clear keeps its bit set
    always_comb begin
        gp_clear = '0;
        misc_clear = '0;
        if (wr_gp_stat) begin
            gp_clear = pwdata[GP_N-1:0];
        end
        if (wr_misc_stat) begin
            misc_clear = pwdata[MISC_N-1:0];
        end
    end

    werm_sticky_bank #(
        .WIDTH(GP_N)
    ) u_gp_stat (
        .clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .sw_reset(sw_reset),
        .set_pulse(detected_events.gp),
        .clear_ones(gp_clear),
        .flags(gp_stat)
    );

    werm_sticky_bank #(
        .WIDTH(MISC_N)
    ) u_misc_stat (
        .clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .sw_reset(sw_reset),
        .set_pulse(detected_events.misc),
        .clear_ones(misc_clear),
        .flags(misc_stat)
    );

    ////////////////////////////////////////////////////////////////////////
    // gate mask chosen by supply state
    always_comb begin
        if (main_supply_present) begin
            misc_gate_sel = misc_pwr;
            gp_gate_sel = gp_pwr;
        end else begin
            misc_gate_sel = misc_unpwr;
            gp_gate_sel = GP_GATE_UNPWR;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // raw event gating toward detectors
    // gp bit 4 is the shared phone ring input; one bit serves both uses
    always_comb begin
        next_gated_events.misc = raw_events.misc & misc_gate_sel;
        next_gated_events.gp = raw_events.gp & gp_gate_sel;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gated_events <= '0;
        end else if (clk_en) begin
            gated_events <= next_gated_events;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt routing; no general enable in the path
    // the routing mask doubles as the interrupt enable
    assign routed_gp = gp_stat & gp_route;
    assign routed_misc = misc_stat & misc_route;

    always_comb begin
        next_wake_irq = |routed_gp || |routed_misc;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_irq <= 1'b0;
        end else if (clk_en) begin
            wake_irq <= next_wake_irq;
        end
    end

endmodule : werm_top

//--- werm_pkg.sv
/*
 * werm_pkg: constants, register indices and carrier types of the wake-up
 * event routing masks.
 * assumes: nothing; imported by werm_top and werm_sticky_bank.
 */
package werm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // widths
    localparam int unsigned GP_N = 8;
    localparam int unsigned MISC_N = 5;
    localparam int unsigned APB_AW = 8;
    localparam int unsigned APB_DW = 32;

    ////////////////////////////////////////////////////////////////////////
    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_GP_ROUTE = 8'h16;
    localparam logic [7:0] IDX_MISC_PWR = 8'h17;
    localparam logic [7:0] IDX_GP_PWR = 8'h18;
    localparam logic [7:0] IDX_MISC_UNPWR = 8'h19;
    localparam logic [7:0] IDX_GP_STAT = 8'h1b;
    localparam logic [7:0] IDX_MISC_STAT = 8'h1c;
    localparam logic [7:0] IDX_MISC_ROUTE = 8'h1d;

    ////////////////////////////////////////////////////////////////////////
    // values after reset, and the fixed unpowered gp gate
    localparam logic [7:0] RST_GP_ROUTE = 8'h00;
    localparam logic [4:0] RST_MISC_ROUTE = 5'h00;
    localparam logic [4:0] RST_MISC_GATE = 5'h1f;
    localparam logic [7:0] RST_GP_GATE = 8'hff;
    localparam logic [7:0] GP_GATE_UNPWR = 8'hff;
    localparam logic [7:0] RST_STAT8 = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // misc field positions; gp bit n is input n
    localparam int unsigned BIT_SERIAL1_CALL = 0;
    localparam int unsigned BIT_SERIAL2_CALL = 1;
    localparam int unsigned BIT_KEYBOARD = 2;
    localparam int unsigned BIT_MOUSE = 3;
    localparam int unsigned BIT_INFRARED = 4;
    localparam int unsigned BIT_GP_SHARED_PHONE = 4;

    ////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [MISC_N-1:0] misc;
        logic [GP_N-1:0] gp;
    } werm_events_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [APB_DW-1:0] pwdata;
    } werm_apb_req_t;

    function automatic logic [APB_AW-1:0] werm_byte_addr(input logic [7:0] idx);
        return {idx[APB_AW-3:0], 2'b00};
    endfunction : werm_byte_addr

    function automatic logic [APB_DW-1:0] werm_word(input logic [7:0] val);
        return {24'h000000, val};
    endfunction : werm_word

endpackage : werm_pkg

//--- werm_sticky_bank.sv
/*
 * werm_sticky_bank: sticky event flags, set by hardware pulses, cleared by
 * writing ones.
 * assumes: set and clear are synchronous to clk; clk_en freezes the bank.
 */
`timescale 1ns/1ps
module werm_sticky_bank #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sw_reset,
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic [WIDTH-1:0] clear_ones,
    output logic [WIDTH-1:0] flags
);
    import werm_pkg::*;

    logic [WIDTH-1:0] next_flags;

    ////////////////////////////////////////////////////////////////////////
    // set wins over a clear in the same cycle
    always_comb begin
        next_flags = flags;
        if (sw_reset) begin
            next_flags = '0;
        end else begin
            next_flags = (flags & ~clear_ones) | set_pulse;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= '0;
        end else if (clk_en) begin
            flags <= next_flags;
        end
    end

endmodule : werm_sticky_bank

//--- werm_chk.sv
/* werm_chk: port assertions and covers for werm_top.
   assumes: single clock ref_clk, async active-low reset_n. */
`timescale 1ns/1ps
module werm_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic sw_reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [werm_pkg::APB_AW-1:0] paddr,
    input wire logic [werm_pkg::APB_DW-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire werm_pkg::werm_events_t raw_events,
    input wire werm_pkg::werm_events_t detected_events,
    input wire werm_pkg::werm_events_t gated_events,
    input wire logic wake_irq
);
    import werm_pkg::*;
    logic acc;
    logic mapped;
    assign acc = psel && penable;
    assign mapped = paddr inside {8'h58, 8'h5c, 8'h60, 8'h64, 8'h6c, 8'h70, 8'h74};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_decode: assert property (pslverr == (acc && !mapped))
        else $error("pslverr decode wrong");
    chk_err_rdata: assert property (acc && !pwrite && !mapped |-> prdata == '0)
        else $error("unmapped read data not zero");
    chk_rdata_upper: assert property (prdata[31:8] == '0)
        else $error("read data upper bits set");
    chk_gate_subset: assert property (clk_en |=> (gated_events & ~$past(raw_events)) == '0)
        else $error("gated event without raw event");
    chk_irq_cause: assert property ($rose(wake_irq) |-> $past((detected_events != '0) || (acc && pwrite), 2))
        else $error("irq rose without cause");
    chk_irq_clear: assert property ($fell(wake_irq) |-> $past((acc && pwrite) || sw_reset, 2))
        else $error("irq fell without cause");
    chk_idle_reset: assert property ($rose(reset_n) |-> !wake_irq && gated_events == '0)
        else $error("outputs not idle after reset");
    chk_freeze_hold: assert property (!clk_en |=> $stable(gated_events) && $stable(wake_irq))
        else $error("outputs moved while frozen");
    cov_irq: cover property ($rose(wake_irq));
    cov_err: cover property (acc && pslverr);
    cov_freeze: cover property (!clk_en);
endmodule : werm_chk

bind werm_top werm_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .sw_reset(sw_reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .raw_events(raw_events), .detected_events(detected_events),
    .gated_events(gated_events), .wake_irq(wake_irq));

//--- werm_det.sv
/* werm_det: event detector model, one-cycle pulse per rising gated event.
   assumes: gated_events from werm_top, same clock. */
`timescale 1ns/1ps
module werm_det (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire werm_pkg::werm_events_t gated_events,
    output werm_pkg::werm_events_t detected_events
);
    import werm_pkg::*;
    werm_events_t last;
    werm_events_t next_last;
    werm_events_t next_det;
    always_comb begin
        next_last = gated_events;
        next_det = gated_events & ~last;
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            last <= '0;
            detected_events <= '0;
        end else begin
            last <= next_last;
            detected_events <= next_det;
        end
    end
endmodule : werm_det

//--- tb_top.sv
/* tb_top: self-checking bench for werm_top with an APB master and detector model.
   assumes: werm_pkg, werm_top, werm_det and werm_chk compiled first. */
`timescale 1ns/1ps
module tb_top;
    import werm_pkg::*;
    typedef struct packed {logic [7:0] idx; logic [7:0] rst; logic [7:0] wr; logic [7:0] exp;} werm_row_t;
    logic ref_clk = 0, reset_n = 0, clk_en = 1, sw_reset = 0, main_supply_present = 1;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, wake_irq, er;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    werm_events_t raw_events = '0, detected_events, gated_events;
    int mismatches = 0, compares = 0;
    werm_row_t rows [5] = '{'{8'h16, 8'h00, 8'ha5, 8'ha5}, '{8'h17, 8'h1f, 8'hff, 8'h1f},
        '{8'h18, 8'hff, 8'h5a, 8'h5a}, '{8'h19, 8'h1f, 8'hea, 8'h0a}, '{8'h1d, 8'h00, 8'hff, 8'h1f}};
    always #2 ref_clk = ~ref_clk;
    werm_top dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .sw_reset(sw_reset),
        .main_supply_present(main_supply_present), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .raw_events(raw_events), .detected_events(detected_events), .gated_events(gated_events),
        .wake_irq(wake_irq));
    werm_det src (.ref_clk(ref_clk), .reset_n(reset_n), .gated_events(gated_events),
        .detected_events(detected_events));
    ////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= {idx[5:0], 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge ref_clk);
        penable <= 1;
        for (n = 0; n < 16; n++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            mismatches++;
            results();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 0;
            penable <= 0;
        end
    endtask : apb
    task chk_rst;
        foreach (rows[i]) begin
            apb(0, rows[i].idx, 8'h00);
            chk(rd, {24'h000000, rows[i].rst});
        end
    endtask : chk_rst
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk);
        chk({wake_irq, gated_events, pslverr}, '0);
        reset_n <= 1;
        chk_rst();
        foreach (rows[i]) begin
            apb(1, rows[i].idx, rows[i].wr);
            apb(0, rows[i].idx, 8'h00);
            chk(rd, {24'h000000, rows[i].exp});
        end
        $display("test registers done");
        raw_events <= '1;
        apb(1, 8'h17, 8'h15);
        repeat (2) @(posedge ref_clk);
        chk(gated_events, {5'h15, 8'h5a});
        main_supply_present <= 0;
        repeat (2) @(posedge ref_clk);
        chk(gated_events, {5'h0a, 8'hff});
        $display("test gating done");
        raw_events <= '0;
        main_supply_present <= 1;
        apb(1, 8'h18, 8'hff);
        apb(1, 8'h17, 8'h1f);
        apb(1, 8'h1d, 8'h00);
        apb(1, 8'h16, 8'h10);
        apb(1, 8'h1b, 8'hff);
        apb(1, 8'h1c, 8'hff);
        raw_events.gp <= 8'h01;
        repeat (6) @(posedge ref_clk);
        chk(wake_irq, 0);
        raw_events.gp <= 8'h11;
        repeat (6) @(posedge ref_clk);
        chk(wake_irq, 1);
        apb(0, 8'h1b, 8'h00);
        chk(rd, 32'h00000011);
        apb(1, 8'h1b, 8'h10);
        repeat (3) @(posedge ref_clk);
        chk(wake_irq, 0);
        raw_events.misc <= 5'h04;
        apb(1, 8'h1d, 8'h04);
        repeat (6) @(posedge ref_clk);
        chk(wake_irq, 1);
        apb(0, 8'h1c, 8'h00);
        chk(rd, 32'h00000004);
        $display("test interrupt done");
        apb(1, 8'h00, 8'hff);
        chk(er, 1);
        apb(0, 8'h1a, 8'h00);
        chk(er, 1);
        chk(rd, 32'h0);
        clk_en <= 0;
        raw_events <= '0;
        repeat (3) @(posedge ref_clk);
        chk(gated_events, {5'h04, 8'h11});
        clk_en <= 1;
        $display("test refusal and freeze done");
        sw_reset <= 1;
        @(posedge ref_clk);
        sw_reset <= 0;
        repeat (3) @(posedge ref_clk);
        chk(wake_irq, 0);
        chk_rst();
        apb(1, 8'h16, 8'hff);
        reset_n <= 0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1;
        chk_rst();
        $display("test resets done");
        results();
    end
endmodule : tb_top
